// ===== verilog/gcr_cfg.svh
// Register offsets, field positions, reset values and frame sizes of the config bank.
`ifndef GCR_CFG_SVH
`define GCR_CFG_SVH

// Serial frame: read flag, seven address bits, sixteen data bits.
`define GCR_FRAME_BITS 5'd24
`define GCR_LAST_BIT 5'd23
`define GCR_ADDR_DONE 5'd7
`define GCR_ADDR_W 7

// Register offsets as printed.
`define GCR_ADDR_CHIP_REVISION 7'h41
`define GCR_ADDR_SERIAL_OUTPUT_CONTROL 7'h42
`define GCR_ADDR_GENERAL_CONFIG_PINS_ALARM 7'h44

// Reset values.
`define GCR_RST_SERIAL_OUTPUT_CONTROL 16'h0000
`define GCR_RST_GENERAL_CONFIG_PINS_ALARM 16'h0010

// Field positions of serial_output_control.
`define GCR_BIT_SERIAL_OUT_ENABLE 0
`define GCR_BIT_EARLY_OUTPUT_SHIFT 1

// Field positions of general_config_pins_alarm.
`define GCR_BIT_AMP_ENABLE_POLARITY 15
`define GCR_BIT_AMP_ENABLE_OPEN_DRAIN 14
`define GCR_BIT_MULTI_PIN_POLARITY 5
`define GCR_BIT_MULTI_PIN_OPEN_DRAIN 4
`define GCR_BIT_ALARM_HOLD_OFF 3

// Writable masks; every other bit is reserved and reads as zero.
`define GCR_MASK_SERIAL_OUTPUT_CONTROL 16'h0003
`define GCR_MASK_GENERAL_CONFIG_PINS_ALARM 16'hC038

// Function-select codes of the multi-function pin.
`define GCR_FUNC_ALARM_OUTPUT 6'h02
`define GCR_FUNC_GPIO 6'h04

`endif

// ===== verilog/gcr_pkg.sv
// Types shared by the config bank modules.
`default_nettype none
package gcr_pkg;

  // Configuration bits as seen by the pin logic on clk_in.
  typedef struct packed {
    logic amp_pol;
    logic amp_od;
    logic mp_pol;
    logic mp_od;
    logic hold_off;
  } gcr_pin_cfg_s;

  // Serial-clock domain state.
  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic [4:0] bit_cnt;
    logic [22:0] shin;
    logic [15:0] shout;
    logic fall_bit;
    logic [15:0] sdo_ctrl;
    logic [15:0] gen_cfg;
  } gcr_link_s;

  // System clock domain state.
  typedef struct packed {
    gcr_pin_cfg_s cfg_meta;
    gcr_pin_cfg_s cfg_sync;
    logic alarm_flag;
    logic amp_pin;
    logic amp_oe;
    logic mp_pin;
    logic mp_oe;
  } gcr_sys_s;

  // Retimer state.
  typedef struct packed {
    logic rise_bit;
  } gcr_rise_s;

endpackage
`default_nettype wire

// ===== verilog/gcr_sdo_if.sv
// Carrier between the serial engine and its rising-edge output retimer.
`default_nettype none
interface gcr_sdo_if;
  logic link_rst_n;
  logic fall_bit;
  logic rise_bit;
  modport engine (output link_rst_n, output fall_bit, input rise_bit);
  modport retime (input link_rst_n, input fall_bit, output rise_bit);
endinterface
`default_nettype wire

// ===== verilog/gcr_sdo_retime.sv
// Rising-edge copy of the serial output bit for normal output timing.
`default_nettype none
module gcr_sdo_retime (
  input wire logic sclk_in,
  gcr_sdo_if.retime sdo
);
  import gcr_pkg::*;

  gcr_rise_s st_q;
  gcr_rise_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.rise_bit = sdo.fall_bit;
    if (!sdo.link_rst_n) begin
      st_d.rise_bit = 1'b0;
    end
  end

  always_ff @(posedge sclk_in) begin
    st_q <= st_d;
  end

  assign sdo.rise_bit = st_q.rise_bit;
endmodule
`default_nettype wire

// ===== verilog/gcr_config_bank.sv
// General configuration bank: serial register access, output pin drive, alarm hold.
//
// Operation
// - Early shift with output enabled presents each output bit half a clock sooner.
// - Early shift is ignored whenever serial output enable is cleared.
// - Normal timing: MSB at chip select fall, then changes on rising clock edges; the engine instead shows the data MSB from the ninth rising edge.
// - Early timing: MSB at chip select fall, then changes on falling clock edges; the engine instead shows the data MSB from the eighth falling edge.
// - Serial output driven only while enabled and chip select low, else undriven.
// - In two-wire bus mode serial output is never driven.
// - Amplifier pin copies the amplifier power bit when its polarity bit is 0.
// - Amplifier pin drives the inverse of the power bit when polarity is 1.
// - Amplifier pin is push-pull when bit 14 is 0, open-drain when 1.
// - Multi-function pin output active level: 0 low, 1 high; reset low.
// - Multi-function pin output drive: 0 push-pull, 1 open-drain; reset open-drain.
// - Hold enabled at 0: alarm flag and pin stay set after condition clears.
// - Held alarm clears only after condition subsides and host reads the flag.
// - Hold-off set: alarm flag and pin follow the condition directly.
// - Multi-function pin shows the alarm only under the alarm-output function code.
`include "gcr_cfg.svh"
`default_nettype none
module gcr_config_bank #(
  // Chip revision value; arbitrary, not tied to any real part.
  parameter logic [3:0] REVISION = 4'hA
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  input wire logic i2c_mode_in,
  input wire logic amp_on_in,
  output logic amp_enable_pin_out,
  output logic amp_enable_pin_oe_out,
  input wire logic [5:0] multi_pin_function_select_in,
  input wire logic gpio_level_in,
  input wire logic alarm_cond_in,
  input wire logic flag_read_in,
  output logic global_alarm_flag_out,
  output logic multi_function_pin_out,
  output logic multi_function_pin_oe_out
);
  import gcr_pkg::*;

  gcr_link_s lk_q;
  gcr_link_s lk_d;
  gcr_sys_s sy_q;
  gcr_sys_s sy_d;
  gcr_sdo_if sdo ();

  logic [`GCR_ADDR_W-1:0] frame_addr;
  logic frame_read;
  logic [15:0] read_word;
  logic [15:0] write_word;
  logic out_enable;
  logic early_mode;

  gcr_sdo_retime u_retime (
    .sclk_in(sclk_in),
    .sdo(sdo)
  );

  // The address is complete at the eighth falling edge, with the current bit still on sdi.
  assign frame_read = lk_q.bit_cnt == `GCR_ADDR_DONE ? lk_q.shin[6] : lk_q.shin[22];
  assign frame_addr = lk_q.bit_cnt == `GCR_ADDR_DONE ? {lk_q.shin[5:0], sdi_in}
                                                    : lk_q.shin[21:15];
  assign write_word = {lk_q.shin[14:0], sdi_in};

  always_comb begin
    case (frame_addr)
      `GCR_ADDR_CHIP_REVISION: read_word = {12'h000, REVISION};
      `GCR_ADDR_SERIAL_OUTPUT_CONTROL: read_word = lk_q.sdo_ctrl;
      `GCR_ADDR_GENERAL_CONFIG_PINS_ALARM: read_word = lk_q.gen_cfg;
      default: read_word = 16'h0000;
    endcase
  end

  // Serial engine, sampling data and shifting on falling serial-clock edges.
  always_comb begin
    lk_d = lk_q;
    lk_d.rst_meta = rst_n_in;
    lk_d.rst_sync = lk_q.rst_meta;
    if (!lk_q.rst_sync) begin
      lk_d.bit_cnt = 5'h00;
      lk_d.shin = 23'h000000;
      lk_d.shout = 16'h0000;
      lk_d.fall_bit = 1'b0;
      lk_d.sdo_ctrl = `GCR_RST_SERIAL_OUTPUT_CONTROL;
      lk_d.gen_cfg = `GCR_RST_GENERAL_CONFIG_PINS_ALARM;
    end else if (cs_n_in) begin
      // Edges outside a frame only rearm the bit counter and clear the output bit.
      lk_d.bit_cnt = 5'h00;
      lk_d.fall_bit = 1'b0;
    end else begin
      lk_d.shin = {lk_q.shin[21:0], sdi_in};
      lk_d.shout = {lk_q.shout[14:0], 1'b0};
      lk_d.fall_bit = lk_q.shout[15];
      if (lk_q.bit_cnt == `GCR_ADDR_DONE) begin
        lk_d.fall_bit = read_word[15];
        lk_d.shout = {read_word[14:0], 1'b0};
      end
      if (lk_q.bit_cnt == `GCR_LAST_BIT) begin
        lk_d.bit_cnt = 5'h00;
        lk_d.fall_bit = 1'b0;
        if (!frame_read) begin
          case (frame_addr)
            `GCR_ADDR_SERIAL_OUTPUT_CONTROL: begin
              lk_d.sdo_ctrl = write_word & `GCR_MASK_SERIAL_OUTPUT_CONTROL;
            end
            `GCR_ADDR_GENERAL_CONFIG_PINS_ALARM: begin
              lk_d.gen_cfg = write_word & `GCR_MASK_GENERAL_CONFIG_PINS_ALARM;
            end
            default: begin
              lk_d.gen_cfg = lk_q.gen_cfg;
            end
          endcase
        end
      end else begin
        lk_d.bit_cnt = lk_q.bit_cnt + 5'h01;
      end
    end
  end

  always_ff @(negedge sclk_in) begin
    lk_q <= lk_d;
  end

  assign sdo.link_rst_n = lk_q.rst_sync;
  assign sdo.fall_bit = lk_q.fall_bit;

  assign early_mode = lk_q.sdo_ctrl[`GCR_BIT_EARLY_OUTPUT_SHIFT]
                      & lk_q.sdo_ctrl[`GCR_BIT_SERIAL_OUT_ENABLE];
  assign out_enable = lk_q.sdo_ctrl[`GCR_BIT_SERIAL_OUT_ENABLE] & ~cs_n_in;

  // Both candidates are flops; the mode bit only changes between frames, so the choice is
  // glitch free in practice. The enable follows chip select at once, as the pin must.
  // early or normal
  assign sdo_out = early_mode ? lk_q.fall_bit : sdo.rise_bit;
  assign sdo_oe_out = out_enable & ~i2c_mode_in;

  // Pin and alarm logic on the system clock.
  always_comb begin
    logic amp_level;
    logic mp_active;
    logic mp_level;
    logic mp_drive;
    amp_level = 1'b0;
    mp_active = 1'b0;
    mp_level = 1'b0;
    mp_drive = 1'b0;
    sy_d = sy_q;
    // The config bits are static between writes; two flops settle each one.
    sy_d.cfg_meta.amp_pol = lk_q.gen_cfg[`GCR_BIT_AMP_ENABLE_POLARITY];
    sy_d.cfg_meta.amp_od = lk_q.gen_cfg[`GCR_BIT_AMP_ENABLE_OPEN_DRAIN];
    sy_d.cfg_meta.mp_pol = lk_q.gen_cfg[`GCR_BIT_MULTI_PIN_POLARITY];
    sy_d.cfg_meta.mp_od = lk_q.gen_cfg[`GCR_BIT_MULTI_PIN_OPEN_DRAIN];
    sy_d.cfg_meta.hold_off = lk_q.gen_cfg[`GCR_BIT_ALARM_HOLD_OFF];
    sy_d.cfg_sync = sy_q.cfg_meta;

    if (alarm_cond_in) begin
      sy_d.alarm_flag = 1'b1;
    end else if (sy_q.cfg_sync.hold_off) begin
      sy_d.alarm_flag = 1'b0;
    end else if (flag_read_in) begin
      sy_d.alarm_flag = 1'b0;
    end

    amp_level = amp_on_in;
    if (sy_q.cfg_sync.amp_pol) begin
      amp_level = ~amp_on_in;
    end
    if (sy_q.cfg_sync.amp_od) begin
      sy_d.amp_pin = 1'b0;
      sy_d.amp_oe = ~amp_level;
    end else begin
      sy_d.amp_pin = amp_level;
      sy_d.amp_oe = 1'b1;
    end

    case (multi_pin_function_select_in)
      `GCR_FUNC_ALARM_OUTPUT: begin
        mp_active = sy_d.alarm_flag;
        mp_drive = 1'b1;
      end
      `GCR_FUNC_GPIO: begin
        mp_active = gpio_level_in;
        mp_drive = 1'b1;
      end
      default: begin
        mp_active = 1'b0;
        mp_drive = 1'b0;
      end
    endcase
    mp_level = sy_q.cfg_sync.mp_pol ? mp_active : ~mp_active;
    if (!mp_drive) begin
      sy_d.mp_pin = 1'b0;
      sy_d.mp_oe = 1'b0;
    end else if (sy_q.cfg_sync.mp_od) begin
      sy_d.mp_pin = 1'b0;
      sy_d.mp_oe = ~mp_level;
    end else begin
      sy_d.mp_pin = mp_level;
      sy_d.mp_oe = 1'b1;
    end

    if (!rst_n_in) begin
      sy_d.cfg_meta = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
      sy_d.cfg_sync = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
      sy_d.alarm_flag = 1'b0;
      sy_d.amp_pin = 1'b0;
      sy_d.amp_oe = 1'b1;
      sy_d.mp_pin = 1'b0;
      sy_d.mp_oe = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    sy_q <= sy_d;
  end

  assign global_alarm_flag_out = sy_q.alarm_flag;
  assign amp_enable_pin_out = sy_q.amp_pin;
  assign amp_enable_pin_oe_out = sy_q.amp_oe;
  assign multi_function_pin_out = sy_q.mp_pin;
  assign multi_function_pin_oe_out = sy_q.mp_oe;
endmodule
`default_nettype wire

// ===== test/gcr_config_bank_checker.sv
// Port-level assertions for the general configuration bank.
`default_nettype none
module gcr_config_bank_checker (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic sdo_oe_out,
  input wire logic i2c_mode_in,
  input wire logic amp_on_in,
  input wire logic amp_enable_pin_out,
  input wire logic amp_enable_pin_oe_out,
  input wire logic [5:0] multi_pin_function_select_in,
  input wire logic gpio_level_in,
  input wire logic alarm_cond_in,
  input wire logic global_alarm_flag_out,
  input wire logic multi_function_pin_out,
  input wire logic multi_function_pin_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // A released pin reads high, so the pin level covers both drive types.
  wire logic amp_lvl = amp_enable_pin_oe_out ? amp_enable_pin_out : 1'b1;
  wire logic mp_lvl = multi_function_pin_oe_out ? multi_function_pin_out : 1'b1;
  sequence quiet_s;
    cs_n_in [*4];
  endsequence
  sequence no_out_fn_s;
    (multi_pin_function_select_in != 6'h02 && multi_pin_function_select_in != 6'h04) [*2];
  endsequence
  sdo_off_a: assert property (cs_n_in || i2c_mode_in |-> !sdo_oe_out)
    else $error("serial output driven while deselected or in two-wire mode");
  alarm_set_a: assert property (alarm_cond_in |=> global_alarm_flag_out)
    else $error("alarm flag missing after condition");
  flag_rise_a: assert property ($rose(global_alarm_flag_out) |-> $past(alarm_cond_in))
    else $error("alarm flag rose without condition");
  flag_fall_a: assert property ($fell(global_alarm_flag_out) |-> !$past(alarm_cond_in))
    else $error("alarm flag cleared while condition present");
  od_sink_a: assert property (!amp_enable_pin_oe_out |-> !amp_enable_pin_out)
    else $error("amplifier pin drives high while released");
  amp_follow_a: assert property (quiet_s ##0 $changed(amp_on_in) |=> $changed(amp_lvl))
    else $error("amplifier pin did not follow its power bit");
  mp_gpio_a: assert property (quiet_s ##0 (multi_pin_function_select_in == 6'h04 &&
    $stable(multi_pin_function_select_in) && $changed(gpio_level_in)) |=> $changed(mp_lvl))
    else $error("multi pin did not follow its level");
  mp_idle_a: assert property (no_out_fn_s |=> !multi_function_pin_oe_out)
    else $error("multi pin driven under a non-output function");
  rst_pins_a: assert property ($rose(rst_n_in) |-> !global_alarm_flag_out &&
    amp_enable_pin_oe_out && !multi_function_pin_oe_out)
    else $error("pin reset state wrong");
endmodule
bind gcr_config_bank gcr_config_bank_checker i_chk (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .cs_n_in(cs_n_in),
  .sdo_oe_out(sdo_oe_out),
  .i2c_mode_in(i2c_mode_in),
  .amp_on_in(amp_on_in),
  .amp_enable_pin_out(amp_enable_pin_out),
  .amp_enable_pin_oe_out(amp_enable_pin_oe_out),
  .multi_pin_function_select_in(multi_pin_function_select_in),
  .gpio_level_in(gpio_level_in),
  .alarm_cond_in(alarm_cond_in),
  .global_alarm_flag_out(global_alarm_flag_out),
  .multi_function_pin_out(multi_function_pin_out),
  .multi_function_pin_oe_out(multi_function_pin_oe_out)
);
`default_nettype wire

// ===== test/gcr_spi_host.sv
// Behavioural serial host that frames register reads and writes.
`default_nettype none
module gcr_spi_host (
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // The clock rests low outside these pulses and frames.
  task automatic pulse(input int n);
    repeat (n) begin
      #7.5 sclk_out = 1'b1;
      #7.5 sclk_out = 1'b0;
    end
  endtask
  // The output is sampled late in both half cycles, which tells the two timing modes apart.
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] d,
                      output logic [23:0] hi, output logic [23:0] lo);
    logic [23:0] f;
    f = {rd, a, d};
    // Selecting in the same step as the last idle falling edge would race that edge.
    #1 cs_n_out = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      #1 sdi_out = f[i];
      #6 lo[i] = sdo_in;
      #0.5 sclk_out = 1'b1;
      #7 hi[i] = sdo_in;
      #0.5 sclk_out = 1'b0;
    end
    #7.5 cs_n_out = 1'b1;
    sdi_out = ~sdi_out;
    pulse(1);
  endtask
endmodule
`default_nettype wire

// ===== test/gcr_config_bank_tb_top.sv
// Self-checking bench for the general configuration bank.
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module gcr_config_bank_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] REV = 4'h5; // Arbitrary revision value.
  logic clk_in, rst_n_in, sclk, cs_n, sdi, sdo, sdo_oe, flt_q, i2c, amp_on, amp_pin, amp_oe;
  logic gpio, cond, rdp, flag, mp, mp_oe, oe_seen;
  logic [5:0] fsel;
  logic [23:0] hi, lo, raw;
  int n_errors, cmp_count;
  wire logic sdo_w = sdo_oe ? sdo : flt_q;
  gcr_spi_host i_host (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi), .sdo_in(sdo_w));
  gcr_config_bank #(.REVISION(REV)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .sclk_in(sclk), .cs_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .i2c_mode_in(i2c), .amp_on_in(amp_on), .amp_enable_pin_out(amp_pin),
    .amp_enable_pin_oe_out(amp_oe), .multi_pin_function_select_in(fsel),
    .gpio_level_in(gpio), .alarm_cond_in(cond), .flag_read_in(rdp),
    .global_alarm_flag_out(flag), .multi_function_pin_out(mp), .multi_function_pin_oe_out(mp_oe));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) flt_q <= ~flt_q;
  always @(posedge sclk) if (!cs_n && sdo_oe) oe_seen <= 1'b1;
  // The raw output just before each rising edge shows which timing the engine uses.
  always @(posedge sclk) if (!cs_n) raw <= {raw[22:0], sdo};
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    i_host.xfer(1'b0, a, d, hi, lo);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    i_host.xfer(1'b1, a, 16'h0000, hi, lo);
    `CHK(hi, {8'h00, e})
  endtask
  // Returns {out, oe}: open drain only ever sinks.
  function automatic logic [1:0] drv(input logic lvl, input logic od);
    return od ? {1'b0, ~lvl} : {lvl, 1'b1};
  endfunction
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // The tests need about 12 us; a hang is cut short well after that.
  initial begin
    #150us;
    n_errors++;
    finish_test();
  end
  initial begin
    {rst_n_in, i2c, amp_on, gpio, cond, rdp, flt_q, oe_seen} = '0;
    fsel = 6'h04;
    fork
      i_host.pulse(4);
      tick(5);
    join
    rst_n_in = 1'b1;
    i_host.pulse(3);
    wr(7'h42, 16'h0001);
    rd(7'h44, 16'h0010);
    `CHK(lo[15:0], 16'h0008)
    rd(7'h41, {12'h000, REV});
    wr(7'h41, 16'hFFFF);
    rd(7'h41, {12'h000, REV});
    wr(7'h44, 16'hFFFF);
    rd(7'h44, 16'hC038);
    rd(7'h43, 16'h0000);
    $display("test registers done");
    wr(7'h42, 16'hFFFF);
    rd(7'h44, 16'hC038);
    `CHK(lo, hi)
    rd(7'h42, 16'h0003);
    wr(7'h42, 16'h0002);
    oe_seen = 1'b0;
    i_host.xfer(1'b1, 7'h44, 16'h0000, hi, lo);
    `CHK(oe_seen, 1'b0)
    `CHK(raw, 24'h00601C)
    wr(7'h42, 16'h0001);
    tick(1);
    i2c = 1'b1;
    oe_seen = 1'b0;
    i_host.xfer(1'b1, 7'h41, 16'h0000, hi, lo);
    `CHK(raw, {9'h000, 12'h000, REV[3:1]})
    `CHK(oe_seen, 1'b0)
    tick(1);
    i2c = 1'b0;
    rd(7'h44, 16'hC038);
    `CHK(oe_seen, 1'b1)
    $display("test output timing done");
    for (int k = 0; k < 8; k++) begin
      wr(7'h44, {k[2:1], 8'h00, k[2:1], 4'h0});
      tick(4);
      amp_on = k[0];
      gpio = k[0];
      tick(2);
      `CHK({amp_pin, amp_oe}, drv(k[0] ^ k[2], k[1]))
      `CHK({mp, mp_oe}, drv(~(k[0] ^ k[2]), k[1]))
    end
    fsel = 6'h01;
    tick(4);
    `CHK(mp_oe, 1'b0)
    $display("test pins done");
    fsel = 6'h02;
    wr(7'h44, 16'h0020);
    tick(4);
    cond = 1'b1;
    tick(1);
    cond = 1'b0;
    tick(3);
    `CHK({flag, mp}, 2'b11)
    cond = 1'b1;
    rdp = 1'b1;
    tick(1);
    rdp = 1'b0;
    tick(1);
    `CHK(flag, 1'b1)
    cond = 1'b0;
    rdp = 1'b1;
    tick(1);
    rdp = 1'b0;
    tick(2);
    `CHK({flag, mp}, 2'b00)
    wr(7'h44, 16'h0028);
    tick(4);
    cond = 1'b1;
    tick(2);
    `CHK(flag, 1'b1)
    cond = 1'b0;
    tick(2);
    `CHK({flag, mp}, 2'b00)
    $display("test alarm done");
    finish_test();
  end
endmodule
`default_nettype wire
